/* File: rtl/sfce_pkg.sv */
// Constants and register map of the servo fault code encoder
// Contract
// RULE_01: Raise error 47 if the absolute encoder speed at power-on is above the configured threshold.
// RULE_02: Raise error 48 if the encoder index pulse is missing within a revolution.
// RULE_03: Raise error 49 if the encoder commutation signal shows an invalid pattern.
// RULE_04: A set bit n (0 to 5) of the scale alarm code raises error 50 plus n.
// RULE_05: Raise error 65 when the ccw torque-limit input is flagged above 10 V magnitude.
// RULE_06: Error 65 is checked only for mode 5, or mode 2 or 4 with torque command select 1, or non-torque mode with limit select 0.
// RULE_07: Raise error 66 on cw torque-limit over-range, checked only in non-torque mode with limit select 0.
// RULE_08: Raise error 95 when the recognised motor does not match the drive.
// RULE_09: Report the self-diagnosis code when the control circuit self-check fails.
// RULE_10: Hold the first raised code until an explicit clear or reset; simultaneous causes keep one.
package sfce_pkg;
    localparam logic [7:0] ERR_ABS_STATUS = 8'h2f;
    localparam logic [7:0] ERR_INDEX = 8'h30;
    localparam logic [7:0] ERR_CS = 8'h31;
    localparam logic [7:0] ERR_SCALE_BASE = 8'h32;
    localparam logic [7:0] ERR_CCW_TL = 8'h41;
    localparam logic [7:0] ERR_CW_TL = 8'h42;
    localparam logic [7:0] ERR_MOTOR = 8'h5f;
    localparam int SCALE_BITS = 6;

    localparam logic [3:0] MODE_TORQUE = 4'h2;
    localparam logic [3:0] MODE_POS_TRQ = 4'h4;
    localparam logic [3:0] MODE_VEL_TRQ = 4'h5;
    localparam logic TCS_ANALOG_CCW = 1'b1;
    localparam logic [1:0] TLS_ANALOG = 2'h0;

    localparam logic [2:0] CS_BAD_LOW = 3'h0;
    localparam logic [2:0] CS_BAD_HIGH = 3'h7;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SPEED_THR = 8'h04;
    localparam logic [7:0] OFS_MOTOR_ID = 8'h08;
    localparam logic [7:0] OFS_ERR = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h18;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_TCS_BIT = 4;
    localparam int CTRL_TLS_LSB = 5;
    localparam int ERR_VALID_BIT = 8;
    localparam int ERR_CLEAR_BIT = 0;

    localparam int IRQ_RAISED = 0;
    localparam int IRQ_SCALE = 1;
    localparam int IRQ_DIAG = 2;
    localparam int IRQ_BITS = 3;

    localparam logic [3:0] CTRL_MODE_RST = 4'h0;
    localparam logic CTRL_TCS_RST = 1'b0;
    localparam logic [1:0] CTRL_TLS_RST = 2'h1;
    localparam logic [15:0] SPEED_THR_RST = 16'hffff;
    localparam logic [7:0] MOTOR_ID_RST = 8'h00;
endpackage

/* File: rtl/sfce_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sfce_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= asyncIn;
            stage2_q <= stage1_q;
        end
    end

    assign syncOut = stage2_q;
endmodule
`default_nettype wire

/* File: rtl/sfce_top.sv */
// Fault detection and error code latch of the servo drive
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sfce_top #(
    parameter int SPEED_W = 16,
    parameter int MOTOR_ID_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output logic irq,
    // Encoder, same clock domain
    input wire logic absSpeedValid,
    input wire logic [SPEED_W-1:0] absSpeed,
    input wire logic revMark,
    // Encoder pins
    input wire logic indexPin,
    input wire logic [2:0] commutationPins,
    // External scale, same clock domain
    input wire logic [5:0] scale_alarm_code,
    // Comparator flags of the analog inputs, pins
    input wire logic ccw_torque_limit_input,
    input wire logic cw_torque_limit_input,
    // Motor recognition and self-check, same clock domain
    input wire logic motorIdValid,
    input wire logic [MOTOR_ID_W-1:0] motorId,
    input wire logic diagFault,
    input wire logic [7:0] diagCode,
    // Latched error
    output logic errValid,
    output logic [7:0] errCode
);
    if (SPEED_W < 1 || SPEED_W > 32 || MOTOR_ID_W < 1 || MOTOR_ID_W > 32) begin : g_param_check
        $error("sfce_top: SPEED_W and MOTOR_ID_W must be 1 to 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [5:0] pinsSync;

    sfce_sync #(
        .WIDTH(6)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .asyncIn({cw_torque_limit_input, ccw_torque_limit_input, commutationPins, indexPin}),
        .syncOut(pinsSync)
    );

    logic indexS;
    logic [2:0] csS;
    logic ccwOverS;
    logic cwOverS;
    assign indexS = pinsSync[0];
    assign csS = pinsSync[3:1];
    assign ccwOverS = pinsSync[4];
    assign cwOverS = pinsSync[5];

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [3:0] control_mode_setting_q, control_mode_setting_d;
    logic torque_command_select_q, torque_command_select_d;
    logic [1:0] torque_limit_select_q, torque_limit_select_d;
    logic [SPEED_W-1:0] speedThr_q, speedThr_d;
    logic [MOTOR_ID_W-1:0] motorIdExp_q, motorIdExp_d;
    logic [sfce_pkg::IRQ_BITS-1:0] irqStat_q, irqStat_d;
    logic [sfce_pkg::IRQ_BITS-1:0] irqEn_q, irqEn_d;
    logic [31:0] rdData_q, rdData_d;
    logic errClear;

    // Torque-only mode has no position or velocity loop
    function automatic logic posVelMode(input logic [3:0] mode);
        return mode != sfce_pkg::MODE_TORQUE;
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Detectors

    logic indexPrev_q, indexPrev_d;
    logic indexSeen_q, indexSeen_d;
    logic revArmed_q, revArmed_d;
    logic speedChecked_q, speedChecked_d;
    // Sync stages hold reset zeros, which would read as a bad pattern
    logic [1:0] pinsLive_q, pinsLive_d;
    logic indexRise;
    logic ccwEnabled;
    logic cwEnabled;
    logic [7:0] candCode;
    logic candValid;
    logic scaleHit;

    assign indexRise = indexS && !indexPrev_q;
    assign scaleHit = |scale_alarm_code;

    always_comb begin
        ccwEnabled = 1'b0;
        // see RULE_06
        if (control_mode_setting_q == sfce_pkg::MODE_VEL_TRQ) begin
            ccwEnabled = 1'b1;
        end else if ((control_mode_setting_q == sfce_pkg::MODE_TORQUE
                      || control_mode_setting_q == sfce_pkg::MODE_POS_TRQ)
                     && torque_command_select_q == sfce_pkg::TCS_ANALOG_CCW) begin
            ccwEnabled = 1'b1;
        end
        if (posVelMode(control_mode_setting_q) && torque_limit_select_q == sfce_pkg::TLS_ANALOG) begin
            ccwEnabled = 1'b1;
        end
        // see RULE_07
        cwEnabled = posVelMode(control_mode_setting_q) && torque_limit_select_q == sfce_pkg::TLS_ANALOG;
    end

    always_comb begin
        indexPrev_d = indexS;
        pinsLive_d = {pinsLive_q[0], 1'b1};
        indexSeen_d = indexSeen_q;
        revArmed_d = revArmed_q;
        speedChecked_d = speedChecked_q;
        if (absSpeedValid) begin
            speedChecked_d = 1'b1;
        end
        // First revolution mark only arms the window
        if (revMark) begin
            revArmed_d = 1'b1;
            indexSeen_d = indexRise;
        end else if (indexRise) begin
            indexSeen_d = 1'b1;
        end
    end

    // Lowest fixed code wins when several causes meet in one cycle; the self-diagnosis code is taken last
    always_comb begin
        candValid = 1'b1;
        candCode = 8'h00;
        if (absSpeedValid && !speedChecked_q && absSpeed > speedThr_q) begin
            candCode = sfce_pkg::ERR_ABS_STATUS; // see RULE_01
        end else if (revMark && revArmed_q && !indexSeen_q && !indexRise) begin
            candCode = sfce_pkg::ERR_INDEX; // see RULE_02
        end else if (pinsLive_q[1] && (csS == sfce_pkg::CS_BAD_LOW || csS == sfce_pkg::CS_BAD_HIGH)) begin
            candCode = sfce_pkg::ERR_CS; // see RULE_03
        end else if (scaleHit) begin
            candCode = sfce_pkg::ERR_SCALE_BASE; // see RULE_04
            for (int n = sfce_pkg::SCALE_BITS - 1; n >= 0; n--) begin
                if (scale_alarm_code[n]) begin
                    candCode = sfce_pkg::ERR_SCALE_BASE + 8'(n);
                end
            end
        end else if (pinsLive_q[1] && ccwEnabled && ccwOverS) begin
            candCode = sfce_pkg::ERR_CCW_TL; // see RULE_05
        end else if (pinsLive_q[1] && cwEnabled && cwOverS) begin
            candCode = sfce_pkg::ERR_CW_TL; // see RULE_07
        end else if (motorIdValid && motorId != motorIdExp_q) begin
            candCode = sfce_pkg::ERR_MOTOR; // see RULE_08
        end else if (diagFault) begin
            candCode = diagCode; // see RULE_09
        end else begin
            candValid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error latch

    logic errValid_q, errValid_d;
    logic [7:0] errCode_q, errCode_d;

    // see RULE_10
    always_comb begin
        errValid_d = errValid_q;
        errCode_d = errCode_q;
        if (errClear) begin
            errValid_d = 1'b0;
        end
        // A cause present in the clear cycle is kept, not lost
        if (candValid && (!errValid_q || errClear)) begin
            errValid_d = 1'b1;
            errCode_d = candCode;
        end
    end

    assign errValid = errValid_q;
    assign errCode = errCode_q;

    ////////////////////////////////////////////////////////////////////////
    // Register access

    assign errClear = regWr && hit(regAddr, sfce_pkg::OFS_ERR) && regWrData[sfce_pkg::ERR_CLEAR_BIT];

    always_comb begin
        logic [sfce_pkg::IRQ_BITS-1:0] events;
        events = '0;
        control_mode_setting_d = control_mode_setting_q;
        torque_command_select_d = torque_command_select_q;
        torque_limit_select_d = torque_limit_select_q;
        speedThr_d = speedThr_q;
        motorIdExp_d = motorIdExp_q;
        irqEn_d = irqEn_q;
        irqStat_d = irqStat_q;
        rdData_d = 32'h0000_0000;
        events[sfce_pkg::IRQ_RAISED] = candValid && (!errValid_q || errClear);
        events[sfce_pkg::IRQ_SCALE] = scaleHit;
        events[sfce_pkg::IRQ_DIAG] = diagFault;
        if (regWr) begin
            if (hit(regAddr, sfce_pkg::OFS_CTRL)) begin
                control_mode_setting_d = regWrData[sfce_pkg::CTRL_MODE_LSB +: 4];
                torque_command_select_d = regWrData[sfce_pkg::CTRL_TCS_BIT];
                torque_limit_select_d = regWrData[sfce_pkg::CTRL_TLS_LSB +: 2];
            end
            if (hit(regAddr, sfce_pkg::OFS_SPEED_THR)) begin
                speedThr_d = regWrData[SPEED_W-1:0];
            end
            if (hit(regAddr, sfce_pkg::OFS_MOTOR_ID)) begin
                motorIdExp_d = regWrData[MOTOR_ID_W-1:0];
            end
            if (hit(regAddr, sfce_pkg::OFS_IRQ_EN)) begin
                irqEn_d = regWrData[sfce_pkg::IRQ_BITS-1:0];
            end
            if (hit(regAddr, sfce_pkg::OFS_IRQ_CLR)) begin
                irqStat_d = irqStat_q & ~regWrData[sfce_pkg::IRQ_BITS-1:0];
            end
        end
        // Set wins over clear
        irqStat_d = irqStat_d | events;
        if (regRd) begin
            unique case (regAddr)
                sfce_pkg::OFS_CTRL: begin
                    rdData_d[sfce_pkg::CTRL_MODE_LSB +: 4] = control_mode_setting_q;
                    rdData_d[sfce_pkg::CTRL_TCS_BIT] = torque_command_select_q;
                    rdData_d[sfce_pkg::CTRL_TLS_LSB +: 2] = torque_limit_select_q;
                end
                sfce_pkg::OFS_SPEED_THR: begin
                    rdData_d[SPEED_W-1:0] = speedThr_q;
                end
                sfce_pkg::OFS_MOTOR_ID: begin
                    rdData_d[MOTOR_ID_W-1:0] = motorIdExp_q;
                end
                sfce_pkg::OFS_ERR: begin
                    rdData_d[7:0] = errCode_q;
                    rdData_d[sfce_pkg::ERR_VALID_BIT] = errValid_q;
                end
                sfce_pkg::OFS_IRQ_STAT: begin
                    rdData_d[sfce_pkg::IRQ_BITS-1:0] = irqStat_q;
                end
                sfce_pkg::OFS_IRQ_EN: begin
                    rdData_d[sfce_pkg::IRQ_BITS-1:0] = irqEn_q;
                end
                default: begin
                    rdData_d = 32'h0000_0000;
                end
            endcase
        end
    end

    assign regRdData = rdData_q;
    assign irq = |(irqStat_q & irqEn_q);

    ////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            control_mode_setting_q <= sfce_pkg::CTRL_MODE_RST;
            torque_command_select_q <= sfce_pkg::CTRL_TCS_RST;
            torque_limit_select_q <= sfce_pkg::CTRL_TLS_RST;
            speedThr_q <= SPEED_W'(sfce_pkg::SPEED_THR_RST);
            motorIdExp_q <= MOTOR_ID_W'(sfce_pkg::MOTOR_ID_RST);
            irqStat_q <= '0;
            irqEn_q <= '0;
            rdData_q <= 32'h0000_0000;
            errValid_q <= 1'b0;
            errCode_q <= 8'h00;
            indexPrev_q <= 1'b0;
            pinsLive_q <= 2'h0;
            indexSeen_q <= 1'b0;
            revArmed_q <= 1'b0;
            speedChecked_q <= 1'b0;
        end else begin
            control_mode_setting_q <= control_mode_setting_d;
            torque_command_select_q <= torque_command_select_d;
            torque_limit_select_q <= torque_limit_select_d;
            speedThr_q <= speedThr_d;
            motorIdExp_q <= motorIdExp_d;
            irqStat_q <= irqStat_d;
            irqEn_q <= irqEn_d;
            rdData_q <= rdData_d;
            errValid_q <= errValid_d;
            errCode_q <= errCode_d;
            indexPrev_q <= indexPrev_d;
            pinsLive_q <= pinsLive_d;
            indexSeen_q <= indexSeen_d;
            revArmed_q <= revArmed_d;
            speedChecked_q <= speedChecked_d;
        end
    end
endmodule
`default_nettype wire

/* File: verif/sfce_enc_model.sv */
// Behavioural model of the serial encoder: index pin, commutation pins, revolution mark
`timescale 1ns/1ns
`default_nettype none
module sfce_enc_model (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic dropIndex,
    input wire logic csForce,
    input wire logic [2:0] csBad,
    output logic indexPin,
    output logic [2:0] commutationPins,
    output logic revMark
);
    logic [3:0] phase = 4'h0;
    logic [2:0] step = 3'h0;
    logic [2:0] csSeq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    initial begin
        indexPin = 1'b0;
        revMark = 1'b0;
        commutationPins = 3'h1;
    end
    ////////////////////////////////////////
    // Sixteen cycles a turn keeps the index test short
    always @(posedge ref_clk) begin
        if (run) begin
            phase <= phase + 4'h1;
            if (phase[1:0] == 2'h3) begin
                step <= (step == 3'h5) ? 3'h0 : step + 3'h1;
            end
        end
        indexPin <= run && !dropIndex && (phase == 4'h4 || phase == 4'h5);
        revMark <= run && phase == 4'hf;
        commutationPins <= csForce ? csBad : csSeq[step];
    end
endmodule
`default_nettype wire

/* File: verif/sfce_top_props.sv */
// Port level checks of the fault code encoder
`timescale 1ns/1ns
`default_nettype none
module sfce_top_props (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic irq,
    input wire logic absSpeedValid,
    input wire logic revMark,
    input wire logic [2:0] commutationPins,
    input wire logic [5:0] scale_alarm_code,
    input wire logic ccw_torque_limit_input,
    input wire logic cw_torque_limit_input,
    input wire logic motorIdValid,
    input wire logic diagFault,
    input wire logic [7:0] diagCode,
    input wire logic errValid,
    input wire logic [7:0] errCode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [2:0] calmQ;
    logic [7:0] lowCode;
    logic pinsCalm;
    logic clearWr;
    assign clearWr = regWr && regAddr == sfce_pkg::OFS_ERR && regWrData[0];
    assign pinsCalm = commutationPins != 3'h0 && commutationPins != 3'h7
        && !ccw_torque_limit_input && !cw_torque_limit_input;
    // Pins pass two flops, so they must be calm for three edges
    always_ff @(posedge ref_clk) begin
        calmQ <= rst ? 3'h0 : {calmQ[1:0], pinsCalm};
    end
    always_comb begin
        lowCode = sfce_pkg::ERR_SCALE_BASE;
        for (int i = 5; i >= 0; i--) begin
            if (scale_alarm_code[i]) begin
                lowCode = sfce_pkg::ERR_SCALE_BASE + 8'(i);
            end
        end
    end
    sequence calm_s;
        !errValid && &calmQ && !absSpeedValid && !revMark;
    endsequence
    ////////////////////////////////////////
    rdata_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0) else $error("read data outside slot");
    err_read_a: assert property (regRd && regAddr == sfce_pkg::OFS_ERR |=>
        regRdData == {23'h0, $past(errValid), $past(errCode)}) else $error("error word read wrong");
    hold_err_a: assert property (errValid && !clearWr |=> errValid && $stable(errCode))
        else $error("latched code moved");
    clear_only_a: assert property ($fell(errValid) |-> $past(clearWr)) else $error("code lost");
    scale_code_a: assert property (calm_s ##0 scale_alarm_code != 6'h0 |=>
        errValid && errCode == $past(lowCode)) else $error("scale code wrong");
    diag_code_a: assert property (calm_s ##0 (diagFault && scale_alarm_code == 6'h0 && !motorIdValid) |=>
        errValid && errCode == $past(diagCode)) else $error("diag code wrong");
    reset_clean_a: assert property ($fell(rst) |-> !errValid && !irq && regRdData == 32'h0)
        else $error("outputs not clear after reset");
    irq_drop_a: assert property ($fell(irq) |->
        $past(regWr && (regAddr == sfce_pkg::OFS_IRQ_EN || regAddr == sfce_pkg::OFS_IRQ_CLR)))
        else $error("irq fell alone");
    irq_cause_a: assert property ($rose(irq) |-> $past(regWr && regAddr == sfce_pkg::OFS_IRQ_EN)
        || $rose(errValid) || $past(scale_alarm_code != 6'h0) || $past(diagFault)) else $error("irq rose alone");
endmodule
`default_nettype wire

/* File: verif/test_servo_fault_code_encoder.sv */
// Self-checking bench of the fault code encoder
`timescale 1ns/1ns
`default_nettype none
module test_servo_fault_code_encoder;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] speed = 16'h0;
    logic [5:0] scale = 6'h0;
    logic [7:0] motorId = 8'h0;
    logic [7:0] diagCode = 8'h0;
    logic speedOk = 1'b0, ccw = 1'b0, cw = 1'b0, motorOk = 1'b0, diag = 1'b0;
    logic run = 1'b0, dropIndex = 1'b0, csForce = 1'b0;
    logic [2:0] csBad = 3'h0;
    logic [31:0] regRdData;
    logic [2:0] pins;
    logic irq, revMark, indexPin, errValid;
    logic [7:0] errCode;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int e;
    int md [7] = '{2, 4, 5, 2, 0, 0, 4};
    int tc [7] = '{1, 1, 0, 0, 0, 0, 0};
    int tl [7] = '{1, 1, 1, 0, 0, 1, 1};
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'hfc};
    logic [31:0] rv [8] = '{32'h20, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    always #2 ref_clk = ~ref_clk;
    sfce_top dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .irq(irq), .absSpeedValid(speedOk), .absSpeed(speed),
        .revMark(revMark), .indexPin(indexPin), .commutationPins(pins), .scale_alarm_code(scale),
        .ccw_torque_limit_input(ccw), .cw_torque_limit_input(cw), .motorIdValid(motorOk), .motorId(motorId),
        .diagFault(diag), .diagCode(diagCode), .errValid(errValid), .errCode(errCode));
    sfce_enc_model enc_u (.ref_clk(ref_clk), .run(run), .dropIndex(dropIndex), .csForce(csForce),
        .csBad(csBad), .indexPin(indexPin), .commutationPins(pins), .revMark(revMark));
    ////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        tick(1);
        regWr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        regAddr <= a;
        regRd <= 1'b1;
        tick(1);
        regRd <= 1'b0;
        #1;
        check(regRdData, x);
        tick(1);
    endtask
    task automatic errChk(input logic [7:0] c);
        for (int i = 0; i < 40 && errValid !== 1'b1; i++) tick(1);
        rd(sfce_pkg::OFS_ERR, {23'h0, 1'b1, c});
    endtask
    task automatic clearAll();
        wr(sfce_pkg::OFS_ERR, 32'h1);
        wr(sfce_pkg::OFS_IRQ_CLR, 32'h7);
    endtask
    task automatic speedPulse(input logic [15:0] v);
        speedOk <= 1'b1;
        speed <= v;
        tick(1);
        speedOk <= 1'b0;
        tick(2);
    endtask
    // Model of the analog limit gating per control setting
    function automatic int tlExp(int m, int c, int l, int f);
        if (f == 0 && (m == 5 || ((m == 2 || m == 4) && c == 1) || (m != 2 && l == 0))) return 65;
        if (f == 1 && m != 2 && l == 0) return 66;
        return 0;
    endfunction
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'h3ec9));
        tick(3);
        rst <= 1'b0;
        tick(1);
        wr(sfce_pkg::OFS_IRQ_STAT, 32'h7);
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
        wr(sfce_pkg::OFS_SPEED_THR, 32'h100);
        speedPulse(16'h101);
        errChk(sfce_pkg::ERR_ABS_STATUS);
        clearAll();
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        tick(1);
        wr(sfce_pkg::OFS_SPEED_THR, 32'h100);
        speedPulse(16'h100);
        speedPulse(16'h200);
        check(32'(errValid), 32'h0);
        diagCode <= 8'($urandom);
        diag <= 1'b1;
        tick(1);
        diag <= 1'b0;
        errChk(diagCode);
        check(32'(irq), 32'h0);
        wr(sfce_pkg::OFS_IRQ_EN, 32'h7);
        check(32'(irq), 32'h1);
        rd(sfce_pkg::OFS_IRQ_STAT, 32'h5);
        clearAll();
        check(32'(irq), 32'h0);
        wr(sfce_pkg::OFS_MOTOR_ID, 32'h3c);
        for (int k = 0; k < 2; k++) begin
            motorId <= (k == 0) ? 8'h3c : 8'h3c ^ 8'($urandom | 1);
            motorOk <= 1'b1;
            tick(1);
            motorOk <= 1'b0;
            tick(2);
        end
        errChk(sfce_pkg::ERR_MOTOR);
        clearAll();
        for (int n = 0; n < 6; n++) begin
            scale <= 6'((($urandom << 1) | 1) << n);
            tick(2);
            scale <= 6'h0;
            errChk(sfce_pkg::ERR_SCALE_BASE + 8'(n));
            check(32'(irq), 32'h1);
            clearAll();
            check(32'(irq), 32'h0);
        end
        // Simultaneous causes, then a late one while latched
        scale <= 6'h4;
        motorOk <= 1'b1;
        motorId <= 8'h00;
        tick(1);
        motorOk <= 1'b0;
        diag <= 1'b1;
        tick(1);
        diag <= 1'b0;
        scale <= 6'h0;
        errChk(8'd52);
        clearAll();
        for (int i = 0; i < 7; i++) begin
            wr(sfce_pkg::OFS_CTRL, 32'((tl[i] << 5) | (tc[i] << 4) | md[i]));
            for (int f = 0; f < 2; f++) begin
                ccw <= f == 0;
                cw <= f == 1;
                tick(4);
                ccw <= 1'b0;
                cw <= 1'b0;
                tick(3);
                e = tlExp(md[i], tc[i], tl[i], f);
                if (e != 0) errChk(8'(e));
                else check(32'(errValid), 32'h0);
                clearAll();
            end
        end
        for (int v = 0; v < 2; v++) begin
            csBad <= (v == 0) ? 3'h0 : 3'h7;
            csForce <= 1'b1;
            tick(4);
            csForce <= 1'b0;
            tick(3);
            errChk(sfce_pkg::ERR_CS);
            clearAll();
        end
        run <= 1'b1;
        tick(60);
        check(32'(errValid), 32'h0);
        dropIndex <= 1'b1;
        errChk(sfce_pkg::ERR_INDEX);
        run <= 1'b0;
        dropIndex <= 1'b0;
        clearAll();
        stop_test();
    end
endmodule
bind sfce_top sfce_top_props chk_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq), .absSpeedValid(absSpeedValid),
    .revMark(revMark), .commutationPins(commutationPins), .scale_alarm_code(scale_alarm_code),
    .ccw_torque_limit_input(ccw_torque_limit_input), .cw_torque_limit_input(cw_torque_limit_input),
    .motorIdValid(motorIdValid), .diagFault(diagFault), .diagCode(diagCode), .errValid(errValid),
    .errCode(errCode));
`default_nettype wire
